// File: sarcc_pkg.sv
package sarcc_pkg;

	// ----------------------------------------------------------------
	// Word and field sizes
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int BIT_IDX_W = 4;
	localparam int TRIM_W = 6;
	localparam logic [BIT_IDX_W-1:0] BIT_MSB = 4'hF;
	localparam logic [BIT_IDX_W-1:0] BIT_LSB = 4'h0;
	localparam logic [TRIM_W-1:0] TRIM_MAX = 6'h3F;
	localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int RST_MIN_NS = 100;
	localparam int RST_MIN_CYC_I = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] RST_MIN_CYC = 4'(RST_MIN_CYC_I);
	// Last count of the master clock to sequencer clock divider (ratio of four)
	localparam logic [1:0] SEQ_DIV_LAST = 2'h3;
	// Internal oscillator: one master tick every this many clk_i cycles plus one
	localparam logic [3:0] INT_OSC_LAST = 4'h4;
	// Master pin quiet (low) this long means the internal oscillator runs
	localparam logic [7:0] EXT_IDLE_LAST = 8'h40;

	// ----------------------------------------------------------------
	// Control states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_CAL   = 5'h01,
		ST_TRACK = 5'h02,
		ST_HOLD  = 5'h04,
		ST_ZERO  = 5'h08,
		ST_TRIAL = 5'h10
	} sarcc_state_e;

endpackage : sarcc_pkg

// File: sarcc_sync.sv
`timescale 1ns/1ps
module sarcc_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Asynchronous level in
	input wire logic async_i,
	// Filtered level and its edges
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;
	logic level_nxt;
	logic rise_nxt;
	logic fall_nxt;

	// A change is taken only when the two late stages agree
	always_comb begin
		level_nxt = level_r;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
		end
		rise_nxt = level_nxt & ~level_r;
		fall_nxt = ~level_nxt & level_r;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
			rise_o <= rise_nxt;
			fall_o <= fall_nxt;
		end
	end

	assign level_o = level_r;

endmodule : sarcc_sync

// File: sarcc_ctrl.sv
// Behaviour
// - Each conversion starts with the trial code at half-scale, MSB only.
// - Clear the tried bit if input is below trial; then set next bit.
// - Every bit is tried from MSB to LSB before the result is final.
// - Result saturates all ones above reference, all zeros below range.
// - Bipolar: MSB weight on reference while tracking; offset binary out.
// - Track when idle; on conversion command open switch, ignore input.
// - Hold comparator offsets while tracking; subtract at conversion start. Code raises autozero_o only in ST_ZERO, after hold.
// - Calibration trims each bit to sum of lower bits plus dummy LSB.
// - Pin held low selects internal oscillator, else pin clocks device.
// - All calibration and conversion intervals count master clock cycles.
// - Falling hold edge starts conversion; track resumes automatically.
// - Conversion is sequenced from master clock divided by four.
// - Reset pin high clears logic; calibration begins on its release.
`timescale 1ns/1ps
module sarcc_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Device pins
	input wire logic master_clock_pin_i,
	input wire logic hold_n_i,
	input wire logic adc_rst_i,
	input wire logic bipolar_i,
	// Comparator: high when the held input is not below the DAC level
	input wire logic comp_i,
	// Capacitor array control
	output logic [sarcc_pkg::WORD_W-1:0] dac_code_o,
	output logic track_switch_o,
	output logic msb_to_ref_o,
	output logic autozero_o,
	// Calibration trim port
	output logic [sarcc_pkg::BIT_IDX_W-1:0] cal_bit_o,
	output logic [sarcc_pkg::TRIM_W-1:0] cal_trim_o,
	output logic cal_trim_we_o,
	// Status and result
	output logic calibrating_o,
	output logic converting_o,
	output logic int_osc_en_o,
	output logic [sarcc_pkg::WORD_W-1:0] result_o,
	output logic result_valid_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic mclk_lvl;
	logic mclk_rise;
	logic hold_fall;
	logic rst_lvl;

	sarcc_sync u_sync_mclk (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(master_clock_pin_i),
		.level_o(mclk_lvl),
		.rise_o(mclk_rise),
		.fall_o()
	);

	sarcc_sync u_sync_hold (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(hold_n_i),
		.level_o(),
		.rise_o(),
		.fall_o(hold_fall)
	);

	sarcc_sync u_sync_rst (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(adc_rst_i),
		.level_o(rst_lvl),
		.rise_o(),
		.fall_o()
	);

	// ----------------------------------------------------------------
	// Master clock source and sequencer tick
	// ----------------------------------------------------------------
	logic [7:0] idle_r;
	logic [7:0] idle_nxt;
	logic [3:0] osc_r;
	logic [3:0] osc_nxt;
	logic [1:0] div_r;
	logic [1:0] div_nxt;
	logic int_osc_r;
	logic int_osc_nxt;
	logic seq_tick_r;
	logic seq_tick_nxt;
	logic mclk_tick;
	logic [3:0] rst_cnt_r;
	logic [3:0] rst_cnt_nxt;
	logic rst_act_r;
	logic rst_act_nxt;

	always_comb begin
		idle_nxt = idle_r;
		if (mclk_rise) begin
			idle_nxt = 8'h00;
		end else if (idle_r != sarcc_pkg::EXT_IDLE_LAST) begin
			idle_nxt = idle_r + 8'h01;
		end
		// Quiet low pin falls back to the on-chip oscillator
		int_osc_nxt = (idle_r == sarcc_pkg::EXT_IDLE_LAST) & ~mclk_lvl;
		osc_nxt = (osc_r == sarcc_pkg::INT_OSC_LAST) ? 4'h0 : osc_r + 4'h1;
		mclk_tick = int_osc_r ? (osc_r == sarcc_pkg::INT_OSC_LAST)
			: mclk_rise;
		div_nxt = div_r;
		seq_tick_nxt = 1'b0;
		if (mclk_tick) begin
			div_nxt = div_r + 2'h1;
			seq_tick_nxt = (div_r == sarcc_pkg::SEQ_DIV_LAST);
		end
		// Short glitches on the reset pin are not taken as a reset
		rst_cnt_nxt = 4'h0;
		if (rst_lvl) begin
			rst_cnt_nxt = (rst_cnt_r == sarcc_pkg::RST_MIN_CYC) ? rst_cnt_r
				: rst_cnt_r + 4'h1;
		end
		rst_act_nxt = rst_lvl & (rst_cnt_nxt == sarcc_pkg::RST_MIN_CYC);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idle_r <= 8'h00;
			osc_r <= 4'h0;
			div_r <= 2'h0;
			int_osc_r <= 1'b0;
			seq_tick_r <= 1'b0;
			rst_cnt_r <= 4'h0;
			rst_act_r <= 1'b0;
		end else begin
			idle_r <= idle_nxt;
			osc_r <= osc_nxt;
			div_r <= div_nxt;
			int_osc_r <= int_osc_nxt;
			seq_tick_r <= seq_tick_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			rst_act_r <= rst_act_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Calibration and conversion sequencer
	// ----------------------------------------------------------------
	sarcc_pkg::sarcc_state_e state_r;
	sarcc_pkg::sarcc_state_e state_nxt;
	logic [sarcc_pkg::WORD_W-1:0] trial_r;
	logic [sarcc_pkg::WORD_W-1:0] trial_nxt;
	logic [sarcc_pkg::BIT_IDX_W-1:0] bit_r;
	logic [sarcc_pkg::BIT_IDX_W-1:0] bit_nxt;
	logic [sarcc_pkg::TRIM_W-1:0] trim_r;
	logic [sarcc_pkg::TRIM_W-1:0] trim_nxt;
	logic trim_we_nxt;
	logic [sarcc_pkg::WORD_W-1:0] result_nxt;
	logic valid_nxt;
	logic track_nxt;
	logic msb_ref_nxt;
	logic azero_nxt;
	logic [sarcc_pkg::WORD_W-1:0] decided;
	logic cal_nxt;
	logic conv_nxt;

	always_comb begin
		state_nxt = state_r;
		trial_nxt = trial_r;
		bit_nxt = bit_r;
		trim_nxt = trim_r;
		trim_we_nxt = 1'b0;
		result_nxt = result_o;
		valid_nxt = 1'b0;
		// Input below trial level drops the bit under test
		decided = comp_i ? trial_r
			: trial_r & ~(sarcc_pkg::WORD_ONE << bit_r);
		case (state_r)
			sarcc_pkg::ST_CAL: begin
				// Raise trim while the bit weighs less than lower bits + dummy
				if (seq_tick_r) begin
					if (comp_i && trim_r != sarcc_pkg::TRIM_MAX) begin
						trim_nxt = trim_r + 6'h01;
						trim_we_nxt = 1'b1;
					end else if (bit_r == sarcc_pkg::BIT_MSB) begin
						state_nxt = sarcc_pkg::ST_TRACK;
						bit_nxt = sarcc_pkg::BIT_LSB;
						trim_nxt = sarcc_pkg::TRIM_RST;
					end else begin
						bit_nxt = bit_r + 4'h1;
						trim_nxt = sarcc_pkg::TRIM_RST;
					end
				end
			end
			sarcc_pkg::ST_TRACK: begin
				if (hold_fall) begin
					state_nxt = sarcc_pkg::ST_HOLD;
				end
			end
			sarcc_pkg::ST_HOLD: begin
				// Charge already trapped; wait for sequencer phase
				if (seq_tick_r) begin
					state_nxt = sarcc_pkg::ST_ZERO;
				end
			end
			sarcc_pkg::ST_ZERO: begin
				if (seq_tick_r) begin
					state_nxt = sarcc_pkg::ST_TRIAL;
					trial_nxt = sarcc_pkg::WORD_ONE << sarcc_pkg::BIT_MSB;
					bit_nxt = sarcc_pkg::BIT_MSB;
				end
			end
			sarcc_pkg::ST_TRIAL: begin
				if (seq_tick_r) begin
					if (bit_r == sarcc_pkg::BIT_LSB) begin
						// Only whole words reach the result; no
						// extra clamp needed, a stuck comparator
						// already walks to all ones or all zeros
						result_nxt = decided;
						valid_nxt = 1'b1;
						trial_nxt = sarcc_pkg::WORD_ZERO;
						state_nxt = sarcc_pkg::ST_TRACK;
					end else begin
						trial_nxt = decided
							| (sarcc_pkg::WORD_ONE << (bit_r - 4'h1));
						bit_nxt = bit_r - 4'h1;
					end
				end
			end
			default: begin
				state_nxt = sarcc_pkg::ST_CAL;
			end
		endcase
		if (rst_act_r) begin
			// Reset overrides all; calibration restarts on release
			state_nxt = sarcc_pkg::ST_CAL;
			trial_nxt = sarcc_pkg::WORD_ZERO;
			bit_nxt = sarcc_pkg::BIT_LSB;
			trim_nxt = sarcc_pkg::TRIM_RST;
			trim_we_nxt = 1'b0;
			result_nxt = sarcc_pkg::WORD_ZERO;
			valid_nxt = 1'b0;
		end
		// Switch opens for hold, offset removal and trials
		track_nxt = (state_nxt == sarcc_pkg::ST_TRACK);
		msb_ref_nxt = track_nxt & bipolar_i;
		azero_nxt = (state_nxt == sarcc_pkg::ST_ZERO);
		cal_nxt = (state_nxt == sarcc_pkg::ST_CAL);
		// Next state is always one legal one-hot code
		conv_nxt = ~track_nxt & ~cal_nxt;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= sarcc_pkg::ST_CAL;
			trial_r <= sarcc_pkg::WORD_ZERO;
			bit_r <= sarcc_pkg::BIT_LSB;
			trim_r <= sarcc_pkg::TRIM_RST;
			cal_trim_we_o <= 1'b0;
			result_o <= sarcc_pkg::WORD_ZERO;
			result_valid_o <= 1'b0;
			track_switch_o <= 1'b0;
			msb_to_ref_o <= 1'b0;
			autozero_o <= 1'b0;
			// Reset leaves the sequencer in calibration
			calibrating_o <= 1'b1;
			converting_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			trial_r <= trial_nxt;
			bit_r <= bit_nxt;
			trim_r <= trim_nxt;
			cal_trim_we_o <= trim_we_nxt;
			result_o <= result_nxt;
			result_valid_o <= valid_nxt;
			track_switch_o <= track_nxt;
			msb_to_ref_o <= msb_ref_nxt;
			autozero_o <= azero_nxt;
			calibrating_o <= cal_nxt;
			converting_o <= conv_nxt;
		end
	end

	// Flop-driven views of sequencer state
	assign dac_code_o = trial_r;
	assign cal_bit_o = bit_r;
	assign cal_trim_o = trim_r;
	assign int_osc_en_o = int_osc_r;

endmodule : sarcc_ctrl

// File: sarcc_ctrl_asserts.sv
`timescale 1ns/1ps
module sarcc_ctrl_chk (
	// Clock, reset and inputs
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic master_clock_pin_i,
	input wire logic bipolar_i,
	// Watched outputs
	input wire logic [15:0] dac_code_o,
	input wire logic track_switch_o,
	input wire logic msb_to_ref_o,
	input wire logic autozero_o,
	input wire logic [5:0] cal_trim_o,
	input wire logic cal_trim_we_o,
	input wire logic calibrating_o,
	input wire logic converting_o,
	input wire logic int_osc_en_o,
	input wire logic [15:0] result_o,
	input wire logic result_valid_o
);
	// ----------
	// Previous trial code
	// ----------
	logic [15:0] prev_r;
	logic [15:0] low_bit;
	assign low_bit = prev_r & (~prev_r + 16'h0001);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_r <= 16'h0000;
		end else begin
			prev_r <= dac_code_o;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------
	// Assertions
	// ----------
	trial_first_a: assert property (
		prev_r == 16'h0000 && dac_code_o != 16'h0000
		|-> dac_code_o == 16'h8000) else $error("first trial wrong");
	bit_step_a: assert property (
		converting_o && prev_r != 16'h0000 && dac_code_o != 16'h0000
		&& dac_code_o != prev_r |-> dac_code_o == (prev_r | low_bit >> 1)
		|| dac_code_o == (prev_r ^ low_bit | low_bit >> 1))
		else $error("bit step wrong");
	result_load_a: assert property (
		result_valid_o |-> prev_r[0] && (result_o | 16'h0001) == prev_r
		&& dac_code_o == 16'h0000) else $error("result load wrong");
	track_state_a: assert property (
		track_switch_o == !(converting_o || calibrating_o))
		else $error("track switch wrong");
	bipolar_ref_a: assert property (
		track_switch_o && $past(track_switch_o) && $stable(bipolar_i)
		|-> msb_to_ref_o == bipolar_i) else $error("msb reference wrong");
	autozero_a: assert property (
		autozero_o |-> converting_o ##1 (autozero_o || dac_code_o == 16'h8000))
		else $error("autozero wrong");
	seq_rate_a: assert property (
		int_osc_en_o && converting_o && dac_code_o != prev_r
		|-> ##20 dac_code_o != prev_r) else $error("sequencer rate wrong");
	trim_step_a: assert property (
		cal_trim_we_o |-> calibrating_o && cal_trim_o == $past(cal_trim_o)
		+ 6'h01 ##1 !cal_trim_we_o) else $error("trim step wrong");
	osc_select_a: assert property (
		$rose(master_clock_pin_i) |-> ##[1:8] !int_osc_en_o)
		else $error("oscillator select wrong");
	cover property (result_valid_o && result_o == 16'hFFFF);
	cover property (cal_trim_we_o && cal_trim_o == 6'h03);
	cover property ($fell(int_osc_en_o));
endmodule : sarcc_ctrl_chk

bind sarcc_ctrl sarcc_ctrl_chk sarcc_ctrl_chk_i (
	.clk_i(clk_i), .nrst_i(nrst_i),
	.master_clock_pin_i(master_clock_pin_i), .bipolar_i(bipolar_i),
	.dac_code_o(dac_code_o), .track_switch_o(track_switch_o),
	.msb_to_ref_o(msb_to_ref_o), .autozero_o(autozero_o),
	.cal_trim_o(cal_trim_o), .cal_trim_we_o(cal_trim_we_o),
	.calibrating_o(calibrating_o), .converting_o(converting_o),
	.int_osc_en_o(int_osc_en_o), .result_o(result_o),
	.result_valid_o(result_valid_o));

// File: sarcc_host_model.sv
`timescale 1ns/1ps
module sarcc_host_model (
	// Clock
	input wire logic clk_i,
	// Device side
	input wire logic [15:0] dac_code_i,
	input wire logic calibrating_i,
	input wire logic [5:0] cal_trim_i,
	// Pins driven by the host
	output logic master_clock_pin_o,
	output logic hold_n_o,
	output logic adc_rst_o,
	output logic comp_o
);
	logic [15:0] vin = 16'h0000;
	logic ext_run = 1'b0;
	// Ideal comparator; each bit balances after three trim steps
	assign comp_o = calibrating_i ? cal_trim_i < 6'h03 : vin >= dac_code_i;
	initial begin
		hold_n_o = 1'b1;
		adc_rst_o = 1'b0;
		master_clock_pin_o = 1'b0;
		// Pin rests low when idle so the internal oscillator takes over
		// Each level spans two clk_i samples or more, so the filter keeps it
		forever #110 master_clock_pin_o = ext_run & ~master_clock_pin_o;
	end
	task automatic sample();
		@(posedge clk_i);
		#1 hold_n_o = 1'b0;
		repeat (8) @(posedge clk_i);
		#1 hold_n_o = 1'b1;
	endtask : sample
	task automatic pulse_rst();
		@(posedge clk_i);
		#1 adc_rst_o = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 adc_rst_o = 1'b0;
	endtask : pulse_rst
endmodule : sarcc_host_model

// File: sarcc_ctrl_tb_top.sv
`timescale 1ns/1ps
module sarcc_ctrl_tb_top;
	logic clk_i, nrst_i, master_clock_pin_i, hold_n_i, adc_rst_i;
	logic bipolar_i, comp_i, track_switch_o, msb_to_ref_o, autozero_o;
	logic cal_trim_we_o, calibrating_o, converting_o, int_osc_en_o;
	logic result_valid_o;
	logic [15:0] dac_code_o, result_o;
	logic [3:0] cal_bit_o;
	logic [5:0] cal_trim_o;
	int miscompares = 0;
	int total_checks = 0;
	sarcc_ctrl sarcc_ctrl_i (
		.clk_i(clk_i), .nrst_i(nrst_i),
		.master_clock_pin_i(master_clock_pin_i),
		.hold_n_i(hold_n_i), .adc_rst_i(adc_rst_i),
		.bipolar_i(bipolar_i), .comp_i(comp_i),
		.dac_code_o(dac_code_o), .track_switch_o(track_switch_o),
		.msb_to_ref_o(msb_to_ref_o), .autozero_o(autozero_o),
		.cal_bit_o(cal_bit_o), .cal_trim_o(cal_trim_o),
		.cal_trim_we_o(cal_trim_we_o), .calibrating_o(calibrating_o),
		.converting_o(converting_o), .int_osc_en_o(int_osc_en_o),
		.result_o(result_o), .result_valid_o(result_valid_o));
	sarcc_host_model host_i (
		.clk_i(clk_i), .dac_code_i(dac_code_o),
		.calibrating_i(calibrating_o), .cal_trim_i(cal_trim_o),
		.master_clock_pin_o(master_clock_pin_i), .hold_n_o(hold_n_i),
		.adc_rst_o(adc_rst_i), .comp_o(comp_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Whole run is under 20000 cycles; this is ample margin
	initial begin
		#2000000;
		miscompares++;
		end_of_test();
	end
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic t_cal();
		int n;
		int pulses;
		n = 0;
		pulses = 0;
		while (track_switch_o !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
			if (cal_trim_we_o === 1'b1) begin
				// Three trim steps per bit, bits upward from 0
				check({12'h000, cal_bit_o}, 16'(pulses / 3));
				pulses++;
			end
		end
		check(16'(pulses), 16'h0030);
		check({15'h0000, calibrating_o}, 16'h0000);
	endtask : t_cal
	task automatic t_conv(input logic [15:0] v, input logic bip,
		input int lo, input int hi);
		int n;
		n = 0;
		host_i.vin = v;
		bipolar_i = bip;
		tick(3);
		check({15'h0000, msb_to_ref_o}, {15'h0000, bip});
		fork
			host_i.sample();
		join_none
		while (result_valid_o !== 1'b1 && n < 600) begin
			tick(1);
			n++;
		end
		check(16'(n >= lo && n <= hi), 16'h0001);
		check(result_o, v);
		check({15'h0000, track_switch_o}, 16'h0001);
	endtask : t_conv
	task automatic t_ext();
		host_i.ext_run = 1'b1;
		tick(20);
		check({15'h0000, int_osc_en_o}, 16'h0000);
		t_conv(16'h3C96, 1'b0, 295, 335);
		host_i.ext_run = 1'b0;
		tick(120);
		check({15'h0000, int_osc_en_o}, 16'h0001);
	endtask : t_ext
	// Second reset lands mid-calibration; hold there must be lost
	task automatic t_rst();
		host_i.pulse_rst();
		tick(300);
		host_i.pulse_rst();
		// Let the reset take hold so no stale trim pulse is counted
		tick(4);
		fork
			host_i.sample();
		join_none
		t_cal();
		tick(30);
		check({15'h0000, converting_o}, 16'h0000);
	endtask : t_rst
	initial begin
		nrst_i = 1'b0;
		bipolar_i = 1'b0;
		tick(5);
		nrst_i = 1'b1;
		t_cal();
		t_conv(16'h0000, 1'b0, 330, 370);
		t_conv(16'hFFFF, 1'b0, 330, 370);
		t_conv(16'h8000, 1'b1, 330, 370);
		t_conv(16'h7FFF, 1'b1, 330, 370);
		t_conv(16'hA5C3, 1'b0, 330, 370);
		t_ext();
		t_rst();
		end_of_test();
	end
endmodule : sarcc_ctrl_tb_top
